/* bench/bax_exec_monitor.sv */
// Purpose : port checks on the byte alu executor
// Assumes : one clock domain, async active-low reset
// Notes   : attached by bind from the bench top
`timescale 1ns/1ns
module bax_exec_monitor
  import bax_pkg::*;
(
  input wire logic         clock,   // core clock
  input wire logic         arst_n,  // async reset, active low
  input wire bax_apb_req_t apb_req, // apb request group
  input wire bax_apb_rsp_t apb_rsp  // apb answer group
);
  logic acc;
  logic rd;
  logic al;
  logic mapped;
  assign acc    = apb_req.psel & apb_req.penable & apb_rsp.pready;
  assign rd     = acc & !apb_req.pwrite;
  assign al     = apb_req.paddr[1:0] == 2'h0;
  assign mapped = al & ((apb_req.paddr <= BAX_ADDR_EXEC)
                  | ((apb_req.paddr & BAX_MEM_MASK) == BAX_ADDR_MEM));
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////
  sequence s_instr_wr;
    acc && apb_req.pwrite && apb_req.paddr == BAX_ADDR_INSTR;
  endsequence
  sequence s_busy4;
    !apb_rsp.pready [*4] ##1 apb_rsp.pready;
  endsequence
  instr_busy_a: assert property (s_instr_wr |=> s_busy4)
    else $error("instruction cycle is not four clocks");
  busy_cause_a: assert property ($fell(apb_rsp.pready) |->
    $past(acc && apb_req.pwrite && apb_req.paddr == BAX_ADDR_INSTR))
    else $error("busy without an instruction write");
  err_unmapped_a: assert property (acc && al && !mapped |-> apb_rsp.pslverr)
    else $error("unmapped access without error");
  err_mapped_a: assert property (acc && mapped |-> !apb_rsp.pslverr)
    else $error("mapped access flagged as error");
  err_idle_a: assert property (!(apb_req.psel && apb_req.penable) |-> !apb_rsp.pslverr)
    else $error("error outside access phase");
  unmapped_zero_a: assert property (rd && al && !mapped |-> apb_rsp.prdata == 32'h0)
    else $error("unmapped read not zero");
  exec_idle_a: assert property (rd && apb_req.paddr == BAX_ADDR_EXEC |->
    !apb_rsp.prdata[BAX_EX_BUSY] && apb_rsp.prdata[31:28] == 4'h0)
    else $error("status shows busy when answered");
  flags_width_a: assert property (rd && apb_req.paddr == BAX_ADDR_FLAGS |->
    apb_rsp.prdata[31:5] == 27'h0) else $error("flags upper bits set");
  wreg_width_a: assert property (rd && apb_req.paddr == BAX_ADDR_WREG |->
    apb_rsp.prdata[31:8] == 24'h0) else $error("accumulator upper bits set");
endmodule : bax_exec_monitor

/* bench/bax_exec_tb.sv */
// Purpose : directed tests of the byte alu executor over apb
// Assumes : 125 mhz clock, reset held 12 cycles
// Notes   : the first access after each instruction write is stalled by pready
`timescale 1ns/1ns
module byte_alu_instruction_exec_tb_top
  import bax_pkg::*;
;
  logic         clock;
  logic         arst_n;
  bax_apb_req_t apb_req;
  bax_apb_rsp_t apb_rsp;
  int           failures;
  int           compares;
  int           cycles;
  logic [31:0]  r;
  logic         e;
  logic [12:0]  x;
  logic [11:0]  ea;
  logic [15:0]  lit [5] = '{16'h1015, 16'h01FF, 16'h7F01, 16'h8080, 16'h0000};
  logic [8:0]   ix [4] = '{9'h005, 9'h05F, 9'h060, 9'h105};
  initial clock = 1'b0;
  always #4 clock = ~clock;
  bax_exec dut (.clock(clock), .arst_n(arst_n), .apb_req(apb_req), .apb_rsp(apb_rsp));
  ////////////////////////////////////////////////////////////////
  task summarize;
    $display("counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize
  task check(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares = compares + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask : check
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    // look mid-cycle, where pready and prdata stand settled for the coming edge
    @(negedge clock);
    while (apb_rsp.pready !== 1'b1)
      @(negedge clock);
    r = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    @(posedge clock);
    apb_req <= '0;
  endtask : apb
  task rd(input logic [11:0] a, input logic [31:0] v, input string m);
    apb(1'b0, a, 32'h0);
    check(r, v, m);
  endtask : rd
  task ex(input logic [15:0] i);
    apb(1'b1, BAX_ADDR_INSTR, {16'h0, i});
  endtask : ex
  function automatic logic [12:0] add8(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, b};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    return {s[7], a[7] == b[7] && s[7] != a[7], s[7:0] == 8'h0, h[4], s[8], s[7:0]};
  endfunction : add8
  ////////////////////////////////////////////////////////////////
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      failures = failures + 1;
      summarize();
    end
  end
  initial
  begin
    apb_req = '0;
    arst_n = 1'b0;
    failures = 0;
    compares = 0;
    cycles = 0;
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    rd(BAX_ADDR_WREG, 32'h0, "wreg reset");
    rd(BAX_ADDR_FLAGS, 32'h0, "flags reset");
    rd(BAX_ADDR_EXEC, 32'h0, "exec reset");
    $display("test reset done");
    foreach (lit[i])
    begin
      x = add8(lit[i][15:8], lit[i][7:0]);
      apb(1'b1, BAX_ADDR_WREG, {24'h0, lit[i][15:8]});
      ex({BAX_OP_ADDLIT, lit[i][7:0]});
      rd(BAX_ADDR_WREG, {24'h0, x[7:0]}, "addlit sum");
      rd(BAX_ADDR_FLAGS, {27'h0, x[12:8]}, "addlit flags");
    end
    $display("test add literal done");
    apb(1'b1, BAX_ADDR_WREG, 32'h17);
    apb(1'b1, BAX_ADDR_MEM + 12'h008, 32'hC2);
    ex(16'h2402);
    x = add8(8'h17, 8'hC2);
    rd(BAX_ADDR_WREG, 32'hD9, "addfile to wreg");
    rd(BAX_ADDR_MEM + 12'h008, 32'hC2, "addfile file kept");
    rd(BAX_ADDR_FLAGS, {27'h0, x[12:8]}, "addfile flags");
    ex(16'h2602);
    x = add8(8'hD9, 8'hC2);
    rd(BAX_ADDR_MEM + 12'h008, {24'h0, x[7:0]}, "addfile to file");
    rd(BAX_ADDR_WREG, 32'hD9, "addfile wreg kept");
    $display("test add file done");
    apb(1'b1, BAX_ADDR_BANK, 32'h5);
    ex(16'h2527);
    rd(BAX_ADDR_EXEC, 32'h05270000, "banked address");
    ex(16'h2467);
    rd(BAX_ADDR_EXEC, 32'h0F670000, "access bank high");
    apb(1'b1, BAX_ADDR_CTRL, 32'h1);
    apb(1'b1, BAX_ADDR_IXBASE, 32'h100);
    foreach (ix[i])
    begin
      ea = ix[i][8] ? {4'h5, ix[i][7:0]} : (ix[i][7:0] <= 8'h5F) ? 12'h100 + ix[i][6:0]
           : {4'hF, ix[i][7:0]};
      ex({7'h0C, ix[i]});
      rd(BAX_ADDR_EXEC, {4'h0, ea, 14'h0, !ix[i][8] && ix[i][7:0] <= 8'h5F, 1'b0},
         "indexed mode");
    end
    $display("test addressing done");
    apb(1'b1, BAX_ADDR_CTRL, 32'h0);
    apb(1'b1, BAX_ADDR_FLAGS, 32'h0B);
    apb(1'b1, BAX_ADDR_WREG, 32'hB5);
    apb(1'b1, BAX_ADDR_MEM + 12'h03C, 32'hAF);
    ex(16'h1A0F);
    rd(BAX_ADDR_MEM + 12'h03C, 32'h1A, "xor to file");
    rd(BAX_ADDR_FLAGS, 32'h0B, "xor keeps c dc ov");
    ex(16'h180F);
    rd(BAX_ADDR_WREG, 32'hAF, "xor to wreg");
    rd(BAX_ADDR_FLAGS, 32'h1B, "xor negative");
    apb(1'b1, BAX_ADDR_WREG, 32'h1A);
    ex(16'h180F);
    rd(BAX_ADDR_FLAGS, 32'h0F, "xor zero");
    $display("test xor done");
    ex(16'hFFFF);
    apb(1'b0, BAX_ADDR_EXEC, 32'h0);
    check(r & 32'h4, 32'h4, "illegal opcode flag");
    rd(BAX_ADDR_WREG, 32'h0, "illegal leaves wreg");
    apb(1'b0, 12'h020, 32'h0);
    check({r[30:0], e}, 32'h1, "unmapped read");
    $display("test refusals done");
    summarize();
  end
endmodule : byte_alu_instruction_exec_tb_top
bind bax_exec bax_exec_monitor u_mon (.clock(clock), .arst_n(arst_n), .apb_req(apb_req),
  .apb_rsp(apb_rsp));

/* verilog/bax_exec.sv */
// Purpose : decode and execute add-literal, add-to-file and xor-with-file
// Assumes : apb inputs are synchronous to clock; one instruction at a time
// Notes   : one instruction cycle is four clocks, one per phase
// Behaviour
// - add literal to accumulator, five flags
// - add accumulator to file, five flags
// - dest bit selects accumulator or file
// - access bit selects access bank or banked
// - extended mode indexes access addresses up to 95
// - xor accumulator with file, n and z
// - one word, four phases, one cycle
// - indexed offsets are seven bit fields
`timescale 1ns/1ns
module bax_exec
  import bax_pkg::*;
(
  input  wire logic         clock,   // 125 mhz core clock
  input  wire logic         arst_n,  // async reset, active low
  input  wire bax_apb_req_t apb_req, // apb request group
  output bax_apb_rsp_t      apb_rsp  // apb answer group
);

  typedef struct packed {
    bax_phase_t                        phase;
    logic                              ext_en;
    logic [15:0]                       ir;
    logic [7:0]                        wreg;
    logic [3:0]                        bank;
    logic [4:0]                        flags;
    logic [11:0]                       ixbase;
    logic [11:0]                       ea;
    logic                              indexed;
    logic                              illegal;
    logic [7:0]                        opnd;
    logic [7:0]                        res;
    logic [4:0]                        res_flags;
    logic [BAX_MEM_WORDS-1:0][7:0]     mem;
    logic [31:0]                       prdata;
  } bax_state_t;

  bax_state_t st;
  bax_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic is_addlit(input logic [15:0] ir);
    is_addlit = (ir[15:8] == BAX_OP_ADDLIT);
  endfunction : is_addlit

  function automatic logic is_addfile(input logic [15:0] ir);
    is_addfile = (ir[15:10] == BAX_OP_ADDFILE);
  endfunction : is_addfile

  function automatic logic is_xorfile(input logic [15:0] ir);
    is_xorfile = (ir[15:10] == BAX_OP_XORFILE);
  endfunction : is_xorfile

  function automatic logic [BAX_MEM_IW-1:0] mem_idx(input logic [11:0] a);
    mem_idx = a[BAX_MEM_IW-1:0];
  endfunction : mem_idx

  // effective file address: indexed, access bank or banked
  function automatic logic [12:0] eff_addr(input logic [15:0] ir,
                                           input logic        ext_en,
                                           input logic [3:0]  bank,
                                           input logic [11:0] ixbase);
    logic [7:0]           f;
    logic [BAX_OFS_W-1:0] ofs;
    f   = ir[7:0];
    ofs = f[BAX_OFS_W-1:0];
    if (ir[BAX_BIT_ACCESS])
      eff_addr = {1'b0, bank, f};
    else if (ext_en && (f <= BAX_IDX_MAX))
      eff_addr = {1'b1, ixbase + {5'h00, ofs}};
    else if (f < BAX_ACC_SPLIT)
      eff_addr = {1'b0, 4'h0, f};
    else
      eff_addr = {1'b0, BAX_SFR_BANK, f};
  endfunction : eff_addr

  // sum with carry, digit carry, overflow, negative, zero
  function automatic logic [12:0] add8(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] lo;
    logic [4:0] fl;
    s  = {1'b0, a} + {1'b0, b};
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    fl = '0;
    fl[BAX_F_C]  = s[8];
    fl[BAX_F_DC] = lo[4];
    fl[BAX_F_OV] = (a[7] == b[7]) && (s[7] != a[7]);
    fl[BAX_F_N]  = s[7];
    fl[BAX_F_Z]  = (s[7:0] == 8'h00);
    add8 = {fl, s[7:0]};
  endfunction : add8

  // register read mux, zero for unmapped
  function automatic logic [31:0] reg_read(input bax_state_t s, input logic [11:0] a);
    logic [31:0] r;
    r = 32'h00000000;
    if ((a & BAX_MEM_MASK) == BAX_ADDR_MEM)
      r[7:0] = s.mem[a[BAX_MEM_IW+1:2]];
    else
      case (a)
        BAX_ADDR_CTRL:   r[BAX_CTRL_EXT] = s.ext_en;
        BAX_ADDR_INSTR:  r[15:0] = s.ir;
        BAX_ADDR_WREG:   r[7:0] = s.wreg;
        BAX_ADDR_BANK:   r[3:0] = s.bank;
        BAX_ADDR_FLAGS:  r[4:0] = s.flags;
        BAX_ADDR_IXBASE: r[11:0] = s.ixbase;
        BAX_ADDR_EXEC:
        begin
          r[BAX_EX_BUSY]    = (s.phase != BAX_IDLE);
          r[BAX_EX_INDEXED] = s.indexed;
          r[BAX_EX_ILLEGAL] = s.illegal;
          r[BAX_EX_EA_LSB +: 12] = s.ea;
        end
        default:         r = 32'h00000000;
      endcase
    reg_read = r;
  endfunction : reg_read

  function automatic logic mapped(input logic [11:0] a);
    mapped = ((a & BAX_MEM_MASK) == BAX_ADDR_MEM) || (a == BAX_ADDR_CTRL) ||
             (a == BAX_ADDR_INSTR) || (a == BAX_ADDR_WREG) || (a == BAX_ADDR_BANK) ||
             (a == BAX_ADDR_FLAGS) || (a == BAX_ADDR_IXBASE) || (a == BAX_ADDR_EXEC);
  endfunction : mapped

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic        busy;
  logic        acc_done;
  logic        wr_done;
  logic [12:0] ea_x;
  logic [12:0] sum_x;

  assign busy     = (st.phase != BAX_IDLE);
  assign acc_done = apb_req.psel && apb_req.penable && !busy;
  assign wr_done  = acc_done && apb_req.pwrite && mapped(apb_req.paddr);

  always_comb
  begin
    next_st = st;
    ea_x    = eff_addr(st.ir, st.ext_en, st.bank, st.ixbase);
    sum_x   = add8(st.wreg, st.opnd);
    case (st.phase)
      BAX_IDLE: next_st.phase = BAX_IDLE;
      // decode: classify and resolve the file address
      BAX_Q1:
      begin
        next_st.illegal = !(is_addlit(st.ir) || is_addfile(st.ir) || is_xorfile(st.ir));
        next_st.indexed = is_addlit(st.ir) ? 1'b0 : ea_x[12];
        next_st.ea      = is_addlit(st.ir) ? 12'h000 : ea_x[11:0];
        next_st.phase   = BAX_Q2;
      end
      // read operand: literal or file register
      BAX_Q2:
      begin
        next_st.opnd  = is_addlit(st.ir) ? st.ir[7:0] : st.mem[mem_idx(st.ea)];
        next_st.phase = BAX_Q3;
      end
      // process data
      BAX_Q3:
      begin
        if (is_xorfile(st.ir))
        begin
          next_st.res                  = st.wreg ^ st.opnd;
          next_st.res_flags            = st.flags;
          next_st.res_flags[BAX_F_N]   = next_st.res[7];
          next_st.res_flags[BAX_F_Z]   = (next_st.res == 8'h00);
        end
        else
        begin
          next_st.res       = sum_x[7:0];
          next_st.res_flags = sum_x[12:8];
        end
        next_st.phase = BAX_Q4;
      end
      // write destination and flags
      BAX_Q4:
      begin
        if (!st.illegal)
        begin
          next_st.flags = st.res_flags;
          if (is_addlit(st.ir) || !st.ir[BAX_BIT_DEST])
            next_st.wreg = st.res;
          else
            next_st.mem[mem_idx(st.ea)] = st.res;
        end
        next_st.phase = BAX_IDLE;
      end
      default: next_st.phase = BAX_IDLE;
    endcase

    // register writes; only accepted while idle
    if (wr_done)
    begin
      if ((apb_req.paddr & BAX_MEM_MASK) == BAX_ADDR_MEM)
        next_st.mem[apb_req.paddr[BAX_MEM_IW+1:2]] = apb_req.pwdata[7:0];
      else
        case (apb_req.paddr)
          BAX_ADDR_CTRL:   next_st.ext_en = apb_req.pwdata[BAX_CTRL_EXT];
          BAX_ADDR_INSTR:
          begin
            next_st.ir    = apb_req.pwdata[15:0];
            next_st.phase = BAX_Q1;
          end
          BAX_ADDR_WREG:   next_st.wreg = apb_req.pwdata[7:0];
          BAX_ADDR_BANK:   next_st.bank = apb_req.pwdata[3:0];
          BAX_ADDR_FLAGS:  next_st.flags = apb_req.pwdata[4:0];
          BAX_ADDR_IXBASE: next_st.ixbase = apb_req.pwdata[11:0];
          default:         next_st.ext_en = st.ext_en;
        endcase
    end

    // read data follows the address one cycle behind and shows the state loaded at the same edge
    next_st.prdata = reg_read(next_st, apb_req.paddr);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st        <= '0;
      st.phase  <= BAX_IDLE;
      st.ir     <= BAX_RST_INSTR;
      st.wreg   <= BAX_RST_BYTE;
      st.ixbase <= BAX_RST_IXBASE;
    end
    else
      st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer

  assign apb_rsp.pready  = !busy;
  assign apb_rsp.prdata  = st.prdata;
  assign apb_rsp.pslverr = acc_done && !mapped(apb_req.paddr);

endmodule : bax_exec

/* verilog/bax_pkg.sv */
// Purpose : shared constants and types of the byte alu executor
// Assumes : apb with 32-bit data, one aligned word per register
// Notes   : the file memory is a small window indexed by the low address bits
package bax_pkg;

  // apb byte addresses
  localparam logic [11:0] BAX_ADDR_CTRL   = 12'h000;
  localparam logic [11:0] BAX_ADDR_INSTR  = 12'h004;
  localparam logic [11:0] BAX_ADDR_WREG   = 12'h008;
  localparam logic [11:0] BAX_ADDR_BANK   = 12'h00C;
  localparam logic [11:0] BAX_ADDR_FLAGS  = 12'h010;
  localparam logic [11:0] BAX_ADDR_IXBASE = 12'h014;
  localparam logic [11:0] BAX_ADDR_EXEC   = 12'h018;
  localparam logic [11:0] BAX_ADDR_MEM    = 12'h040;
  localparam logic [11:0] BAX_MEM_MASK    = 12'hFC0;

  // file memory
  localparam int          BAX_MEM_WORDS   = 16;
  localparam int          BAX_MEM_IW      = 4;

  // opcode matches
  localparam logic [7:0]  BAX_OP_ADDLIT   = 8'h0F;
  localparam logic [5:0]  BAX_OP_ADDFILE  = 6'h09;
  localparam logic [5:0]  BAX_OP_XORFILE  = 6'h06;

  // bit positions of the instruction word
  localparam int          BAX_BIT_DEST    = 9;
  localparam int          BAX_BIT_ACCESS  = 8;

  // access bank split and indexed range
  localparam logic [7:0]  BAX_ACC_SPLIT   = 8'h60;
  localparam logic [7:0]  BAX_IDX_MAX     = 8'h5F;
  localparam logic [3:0]  BAX_SFR_BANK    = 4'hF;
  localparam int          BAX_OFS_W       = 7;

  // flag positions
  localparam int          BAX_F_C         = 0;
  localparam int          BAX_F_DC        = 1;
  localparam int          BAX_F_Z         = 2;
  localparam int          BAX_F_OV        = 3;
  localparam int          BAX_F_N         = 4;

  // control and exec-status bit positions
  localparam int          BAX_CTRL_EXT    = 0;
  localparam int          BAX_EX_BUSY     = 0;
  localparam int          BAX_EX_INDEXED  = 1;
  localparam int          BAX_EX_ILLEGAL  = 2;
  localparam int          BAX_EX_EA_LSB   = 16;

  // reset values
  localparam logic [15:0] BAX_RST_INSTR   = 16'h0000;
  localparam logic [7:0]  BAX_RST_BYTE    = 8'h00;
  localparam logic [11:0] BAX_RST_IXBASE  = 12'h000;

  typedef enum logic [2:0] {
    BAX_IDLE = 3'b000,
    BAX_Q1   = 3'b001,
    BAX_Q2   = 3'b010,
    BAX_Q3   = 3'b011,
    BAX_Q4   = 3'b100
  } bax_phase_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } bax_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } bax_apb_rsp_t;

endpackage : bax_pkg
